// *** rtl/dma_pkg.sv ***
package dma_pkg;
	// register byte offsets
	localparam logic [5:0] OFS_CTRL   = 6'h00;
	localparam logic [5:0] OFS_SRC    = 6'h04;
	localparam logic [5:0] OFS_DST    = 6'h08;
	localparam logic [5:0] OFS_CNT    = 6'h0c;
	localparam logic [5:0] OFS_NSRC   = 6'h10;
	localparam logic [5:0] OFS_NDST   = 6'h14;
	localparam logic [5:0] OFS_NCNT   = 6'h18;
	localparam logic [5:0] OFS_CHAIN  = 6'h1c;
	localparam logic [5:0] OFS_MASTER = 6'h20;
	localparam logic [5:0] OFS_SRCCFG = 6'h24;
	// control register fields
	localparam int BIT_CH_EN    = 0;
	localparam int BIT_END_FLAG = 1;
	localparam int BIT_IRQ_EN   = 2;
	localparam int BIT_SIZE     = 3;
	localparam int BIT_SAMPLE   = 6;
	localparam int BIT_ACK_POL  = 8;
	localparam int BIT_ACK_CYC  = 9;
	localparam int BIT_ACC_POL  = 10;
	localparam int BIT_CHAIN_EN = 11;
	localparam int BIT_SRC_MODE = 12;
	localparam int BIT_DST_MODE = 14;
	localparam int BIT_END_SEL  = 16;
	localparam int BIT_CLR_SEL  = 17;
	localparam int BIT_NSRC_EN  = 18;
	localparam int BIT_NDST_EN  = 19;
	localparam int BIT_FIFO_SEL = 22;
	localparam logic [31:0] CTRL_WMASK = 32'h004f_fffd;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	// master register fields
	localparam int BIT_MASTER_EN = 0;
	localparam int BIT_NMI_STOP  = 1;
	localparam int BIT_ADDR_ERR  = 2;
	// source config register fields
	localparam int BIT_REQ_SRC = 0;
	localparam int BIT_SINGLE  = 2;
	localparam int BIT_DIR_IN  = 3;
	// step codes and units
	localparam logic [1:0] MODE_INC  = 2'h1;
	localparam logic [1:0] MODE_DEC  = 2'h2;
	localparam logic [1:0] SIZE_8    = 2'h0;
	localparam logic [1:0] SIZE_16   = 2'h1;
	localparam logic [1:0] SIZE_32   = 2'h2;
	localparam logic [31:0] STEP_8   = 32'h0000_0001;
	localparam logic [31:0] STEP_16  = 32'h0000_0002;
	localparam logic [31:0] STEP_32  = 32'h0000_0004;
	localparam int FIFO_SHALLOW = 1;
	localparam int FIFO_DEEP    = 16;
	typedef enum logic [1:0] {SRC_AUTO, SRC_EXT, SRC_MOD, SRC_NONE} req_src_t;
	typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_WRITE, ST_SINGLE,
		ST_LINK} chan_st_t;
endpackage

// *** rtl/req_fifo_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface req_fifo_if #(
	parameter int W  = 1,
	parameter int LW = 5
);
	logic          push;
	logic [W-1:0]  wdata;
	logic          pop;
	logic [W-1:0]  rdata;
	logic [LW-1:0] level;
	modport owner (output push, wdata, pop, input rdata, level);
	modport store (input push, wdata, pop, output rdata, level);
endinterface
`default_nettype wire

// *** rtl/req_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module req_fifo #(
	parameter int W     = 1,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic nrst_i,
	// queue port
	req_fifo_if.store q
);
	localparam int LW = $clog2(DEPTH + 1);
	localparam int PW = $clog2(DEPTH);
	generate
		if (DEPTH < 2) begin : g_bad
			$error("req_fifo needs DEPTH of at least 2");
		end
	endgenerate
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [LW-1:0]           cnt;
		logic [W-1:0]            rdata;
	} fifo_st_t;
	fifo_st_t s;
	fifo_st_t n;
	logic     do_push;
	logic     do_pop;
	always_comb begin
		n = s;
		do_pop = q.pop && (s.cnt != '0);
		do_push = q.push && (s.cnt != LW'(DEPTH));
		if (do_push) begin
			n.mem[s.wp] = q.wdata;
			n.wp = (s.wp == PW'(DEPTH - 1)) ? '0 : PW'(s.wp + 1'b1);
		end
		if (do_pop) begin
			n.rp = (s.rp == PW'(DEPTH - 1)) ? '0 : PW'(s.rp + 1'b1);
		end
		n.cnt = LW'(s.cnt + LW'(do_push) - LW'(do_pop));
		// head always visible so the owner can peek before popping
		n.rdata = n.mem[n.rp];
	end
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
	assign q.rdata = s.rdata;
	assign q.level = s.cnt;
endmodule
`default_nettype wire

// *** rtl/dma_chain_channel.sv ***
// Operation
// - request queue holds sixteen entries when depth select is 1 with low-level sampling, one entry otherwise
// - control bits 21 and 20 read as zero, writes to them ignored
// - with next-destination reload on, chain link copies next destination
// - with next-source reload on, chain link copies next source
// - module flag clear on last count cycle, or every transfer if selected
// - end flag on chain and count both zero, or count zero alone if selected
// - end timing select applies even with chaining switched off
// - with irq enable set, end interrupt rises as end flag is set
// - auto-request always behaves as end timing select 1
// - destination fixed, incremented or decremented by 1, 2 or 4
// - destination mode ignored in single address mode, memory to device
// - source fixed, incremented or decremented by 1, 2 or 4
// - source mode ignored in single address mode, device to memory
// - chained transfers happen only with chain enable set
// - request-accepted output active high at polarity 0, low at 1
// - dual address ack in read cycle at select 0, write cycle at 1
// - single address mode always asserts ack on each transfer
// - ack output active high at level 0, active low at 1
// - sampling select: low level at 0, falling edge at 1, unused in auto
// - unit size 8, 16 or 32 bits selects the address step
// - early stop by nmi, address error or enable clear sets no end flag
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dma_chain_channel #(
	parameter int CNT_W      = 24,
	parameter int CHAIN_W    = 8,
	parameter int FIFO_DEPTH = dma_pkg::FIFO_DEEP
) (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// avalon-mm slave
	input  wire logic [5:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// requests and stop causes
	input  wire logic        ext_transfer_request_n_i,
	input  wire logic        module_request_i,
	input  wire logic        nmi_i,
	input  wire logic        addr_error_i,
	// transfer side
	output logic      [31:0] src_addr_o,
	output logic      [31:0] dst_addr_o,
	output logic             read_cycle_o,
	output logic             write_cycle_o,
	output logic             request_accepted_out_o,
	output logic             transfer_ack_out_o,
	output logic             flag_clear_o,
	output logic             transfer_end_irq_o
);
	localparam int LW = $clog2(FIFO_DEPTH + 1);
	generate
		if (CNT_W < 2 || CNT_W > 31 || CHAIN_W < 1 || CHAIN_W > 31
			|| FIFO_DEPTH < 2) begin : g_bad
			$error("dma_chain_channel parameter out of range");
		end
	endgenerate
	typedef struct packed {
		logic [31:0]        ctl;
		logic [31:0]        src;
		logic [31:0]        dst;
		logic [31:0]        nsrc;
		logic [31:0]        ndst;
		logic [CNT_W-1:0]   cnt;
		logic [CNT_W-1:0]   ncnt;
		logic [CHAIN_W-1:0] chain;
		logic               master_enable;
		logic               nmi_stop_flag;
		logic               address_error_flag;
		logic [3:0]         cfg;
		logic               end_seen;
		dma_pkg::chan_st_t  st;
		logic               req_prev;
		logic               wait_r;
		logic [31:0]        rdata;
		logic               rd;
		logic               wr;
		logic               acc;
		logic               ack;
		logic               clr;
		logic               irq;
	} chan_t;
	chan_t s;
	chan_t n;
	req_fifo_if #(.W(1), .LW(LW)) fq ();
	req_fifo #(.W(1), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.q         (fq.store)
	);
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				o[8*i +: 8] = d[8*i +: 8];
			end
		end
		return o;
	endfunction
	logic              run;
	logic              is_auto;
	logic              is_mod;
	logic              single;
	logic              dir_in;
	logic              req_n;
	logic              req_hit;
	logic [LW-1:0]     limit;
	logic              push;
	logic              pop;
	logic              acc_act;
	logic              ack_act;
	logic              last;
	logic [31:0]       unit;
	logic [31:0]       src_step;
	logic [31:0]       dst_step;
	logic [31:0]       wv;
	logic [31:0]       rmux;
	dma_pkg::req_src_t rsrc;
	always_comb begin
		n = s;
		n.rd = 1'b0;
		n.wr = 1'b0;
		n.clr = 1'b0;
		acc_act = 1'b0;
		ack_act = 1'b0;
		pop = 1'b0;
		wv = merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);
		rsrc = dma_pkg::req_src_t'(s.cfg[dma_pkg::BIT_REQ_SRC +: 2]);
		is_auto = (rsrc == dma_pkg::SRC_AUTO);
		is_mod = (rsrc == dma_pkg::SRC_MOD);
		single = s.cfg[dma_pkg::BIT_SINGLE];
		dir_in = s.cfg[dma_pkg::BIT_DIR_IN];
		run = s.ctl[dma_pkg::BIT_CH_EN] && s.master_enable
			&& !s.nmi_stop_flag && !s.address_error_flag;
		last = (s.cnt == CNT_W'(1));
		// register read mux, reserved bits come back as zero
		case (avs_address_i)
			dma_pkg::OFS_CTRL:   rmux = s.ctl;
			dma_pkg::OFS_SRC:    rmux = s.src;
			dma_pkg::OFS_DST:    rmux = s.dst;
			dma_pkg::OFS_CNT:    rmux = 32'(s.cnt);
			dma_pkg::OFS_NSRC:   rmux = s.nsrc;
			dma_pkg::OFS_NDST:   rmux = s.ndst;
			dma_pkg::OFS_NCNT:   rmux = 32'(s.ncnt);
			dma_pkg::OFS_CHAIN:  rmux = 32'(s.chain);
			dma_pkg::OFS_MASTER: rmux = {29'h0, s.address_error_flag,
				s.nmi_stop_flag, s.master_enable};
			dma_pkg::OFS_SRCCFG: rmux = {28'h0, s.cfg};
			default:             rmux = 32'h0000_0000;
		endcase
		// one wait state: request seen, then answered on the next edge
		if ((avs_read_i || avs_write_i) && s.wait_r) begin
			n.wait_r = 1'b0;
			n.rdata = avs_read_i ? rmux : 32'h0000_0000;
			if (avs_read_i && avs_address_i == dma_pkg::OFS_CTRL
				&& s.ctl[dma_pkg::BIT_END_FLAG]) begin
				n.end_seen = 1'b1;
			end
		end else begin
			n.wait_r = 1'b1;
		end
		if (avs_write_i && !s.wait_r) begin
			case (avs_address_i)
				dma_pkg::OFS_CTRL: begin
					wv = merge(s.ctl, avs_writedata_i, avs_byteenable_i);
					n.ctl = wv & dma_pkg::CTRL_WMASK;
					// end flag clears only by writing 0 after reading 1
					n.ctl[dma_pkg::BIT_END_FLAG] = s.ctl[dma_pkg::BIT_END_FLAG]
						&& !(s.end_seen && !wv[dma_pkg::BIT_END_FLAG]);
					n.end_seen = 1'b0;
				end
				dma_pkg::OFS_SRC:    n.src = merge(s.src, wv, avs_byteenable_i);
				dma_pkg::OFS_DST:    n.dst = merge(s.dst, wv, avs_byteenable_i);
				dma_pkg::OFS_CNT:    n.cnt = wv[CNT_W-1:0];
				dma_pkg::OFS_NSRC:   n.nsrc = merge(s.nsrc, wv, avs_byteenable_i);
				dma_pkg::OFS_NDST:   n.ndst = merge(s.ndst, wv, avs_byteenable_i);
				dma_pkg::OFS_NCNT:   n.ncnt = wv[CNT_W-1:0];
				dma_pkg::OFS_CHAIN:  n.chain = wv[CHAIN_W-1:0];
				dma_pkg::OFS_MASTER: begin
					n.master_enable = wv[dma_pkg::BIT_MASTER_EN];
					n.nmi_stop_flag = s.nmi_stop_flag
						&& wv[dma_pkg::BIT_NMI_STOP];
					n.address_error_flag = s.address_error_flag
						&& wv[dma_pkg::BIT_ADDR_ERR];
				end
				dma_pkg::OFS_SRCCFG: n.cfg = wv[3:0];
				default: ;
			endcase
		end
		// hardware set wins over a software clear in the same cycle
		if (nmi_i) begin
			n.nmi_stop_flag = 1'b1;
		end
		if (addr_error_i) begin
			n.address_error_flag = 1'b1;
		end
		// request sampling into the queue
		req_n = is_mod ? !module_request_i : ext_transfer_request_n_i;
		n.req_prev = req_n;
		req_hit = s.ctl[dma_pkg::BIT_SAMPLE] ? (s.req_prev && !req_n)
			: !req_n;
		limit = (s.ctl[dma_pkg::BIT_FIFO_SEL]
			&& !s.ctl[dma_pkg::BIT_SAMPLE]) ? LW'(FIFO_DEPTH)
			: LW'(dma_pkg::FIFO_SHALLOW);
		push = !is_auto && run && req_hit && (fq.level < limit);
		// address step from unit size, prohibited code steps nothing
		case (s.ctl[dma_pkg::BIT_SIZE +: 2])
			dma_pkg::SIZE_8:  unit = dma_pkg::STEP_8;
			dma_pkg::SIZE_16: unit = dma_pkg::STEP_16;
			dma_pkg::SIZE_32: unit = dma_pkg::STEP_32;
			default:          unit = 32'h0000_0000;
		endcase
		case (s.ctl[dma_pkg::BIT_SRC_MODE +: 2])
			dma_pkg::MODE_INC: src_step = s.src + unit;
			dma_pkg::MODE_DEC: src_step = s.src - unit;
			default:           src_step = s.src;
		endcase
		case (s.ctl[dma_pkg::BIT_DST_MODE +: 2])
			dma_pkg::MODE_INC: dst_step = s.dst + unit;
			dma_pkg::MODE_DEC: dst_step = s.dst - unit;
			default:           dst_step = s.dst;
		endcase
		// early stop leaves the end flag alone
		if (!run && s.st != dma_pkg::ST_IDLE) begin
			n.st = dma_pkg::ST_IDLE;
		end else begin
			case (s.st)
				dma_pkg::ST_IDLE: begin
					if (run && !s.ctl[dma_pkg::BIT_END_FLAG]
						&& s.cnt != '0 && (is_auto || fq.level != '0)) begin
						pop = !is_auto;
						acc_act = !is_auto;
						if (single) begin
							n.st = dma_pkg::ST_SINGLE;
							ack_act = 1'b1;
							n.rd = !dir_in;
							n.wr = dir_in;
							n.clr = fq.rdata[0] && (last
								|| s.ctl[dma_pkg::BIT_CLR_SEL]);
						end else begin
							n.st = dma_pkg::ST_READ;
							n.rd = 1'b1;
							ack_act = !s.ctl[dma_pkg::BIT_ACK_CYC];
						end
					end
				end
				dma_pkg::ST_READ: begin
					n.st = dma_pkg::ST_WRITE;
					n.wr = 1'b1;
					ack_act = s.ctl[dma_pkg::BIT_ACK_CYC];
					n.clr = is_mod && (last
						|| s.ctl[dma_pkg::BIT_CLR_SEL]);
				end
				dma_pkg::ST_WRITE, dma_pkg::ST_SINGLE: begin
					if (!(single && dir_in)) begin
						n.src = src_step;
					end
					if (!(single && !dir_in)) begin
						n.dst = dst_step;
					end
					n.cnt = s.cnt - 1'b1;
					n.st = dma_pkg::ST_IDLE;
					if (last) begin
						// select applies whether or not chaining is on
						if (s.ctl[dma_pkg::BIT_END_SEL] || is_auto
							|| s.chain == '0) begin
							n.ctl[dma_pkg::BIT_END_FLAG] = 1'b1;
						end
						if (s.ctl[dma_pkg::BIT_CHAIN_EN]
							&& s.chain != '0) begin
							n.chain = s.chain - 1'b1;
							n.st = dma_pkg::ST_LINK;
						end
					end
				end
				dma_pkg::ST_LINK: begin
					// reload between links, no bus cycle here
					n.cnt = s.ncnt;
					if (s.ctl[dma_pkg::BIT_NSRC_EN]) begin
						n.src = s.nsrc;
					end
					if (s.ctl[dma_pkg::BIT_NDST_EN]) begin
						n.dst = s.ndst;
					end
					n.st = dma_pkg::ST_IDLE;
				end
				default: n.st = dma_pkg::ST_IDLE;
			endcase
		end
		n.acc = acc_act ^ s.ctl[dma_pkg::BIT_ACC_POL];
		n.ack = ack_act ^ s.ctl[dma_pkg::BIT_ACK_POL];
		n.irq = n.ctl[dma_pkg::BIT_END_FLAG]
			&& n.ctl[dma_pkg::BIT_IRQ_EN];
	end
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '0;
			s.ctl <= dma_pkg::CTRL_RST;
			s.st <= dma_pkg::ST_IDLE;
			s.wait_r <= 1'b1;
			s.req_prev <= 1'b1;
		end else begin
			s <= n;
		end
	end
	assign fq.push = push;
	assign fq.wdata = is_mod;
	assign fq.pop = pop;
	assign avs_readdata_o = s.rdata;
	assign avs_waitrequest_o = s.wait_r;
	assign src_addr_o = s.src;
	assign dst_addr_o = s.dst;
	assign read_cycle_o = s.rd;
	assign write_cycle_o = s.wr;
	assign request_accepted_out_o = s.acc;
	assign transfer_ack_out_o = s.ack;
	assign flag_clear_o = s.clr;
	assign transfer_end_irq_o = s.irq;
	// checks
	rsv_read_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(avs_read_i && s.wait_r && avs_address_i == dma_pkg::OFS_CTRL)
		|=> avs_readdata_o[21:20] == 2'h0)
		else $error("reserved control bits read nonzero");
	ndst_load_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(s.st == dma_pkg::ST_LINK && run && s.ctl[dma_pkg::BIT_NDST_EN])
		|=> dst_addr_o == $past(s.ndst))
		else $error("next destination not reloaded");
	nsrc_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(s.st == dma_pkg::ST_LINK && !s.ctl[dma_pkg::BIT_NSRC_EN]
		&& !avs_write_i) |=> $stable(src_addr_o))
		else $error("source changed without reload enable");
	clr_time_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		flag_clear_o |-> (s.cnt == CNT_W'(1)
		|| s.ctl[dma_pkg::BIT_CLR_SEL]))
		else $error("flag clear outside last count cycle");
	end_set_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		($rose(s.ctl[dma_pkg::BIT_END_FLAG]) && !s.ctl[dma_pkg::BIT_END_SEL]
		&& !$past(is_auto)) |-> $past(s.chain) == '0)
		else $error("end flag set while chain count nonzero");
	irq_rise_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		($rose(s.ctl[dma_pkg::BIT_END_FLAG]) && s.ctl[dma_pkg::BIT_IRQ_EN])
		|-> transfer_end_irq_o)
		else $error("end interrupt missing");
	dst_inc_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(s.st == dma_pkg::ST_WRITE && run && !avs_write_i
		&& s.ctl[15:14] == dma_pkg::MODE_INC && s.ctl[4:3] == dma_pkg::SIZE_32)
		|=> dst_addr_o == $past(dst_addr_o) + 32'h0000_0004)
		else $error("destination step wrong");
	ack_read_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(s.st == dma_pkg::ST_IDLE && n.st == dma_pkg::ST_READ
		&& !s.ctl[dma_pkg::BIT_ACK_CYC]) |=> read_cycle_o
		&& transfer_ack_out_o != $past(s.ctl[dma_pkg::BIT_ACK_POL]))
		else $error("ack missing in read cycle");
	ack_single_a: assert property (@(posedge clk_sys_i)
		disable iff (!nrst_i) (n.st == dma_pkg::ST_SINGLE)
		|=> transfer_ack_out_o != $past(s.ctl[dma_pkg::BIT_ACK_POL]))
		else $error("ack missing in single mode");
	stop_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(s.st != dma_pkg::ST_IDLE && !run)
		|=> s.st == dma_pkg::ST_IDLE && $stable(s.ctl[dma_pkg::BIT_END_FLAG])
		)
		else $error("early stop changed end flag");
endmodule
`default_nettype wire

// *** testbench/req_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module req_partner (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic nrst_i,
	// from the channel
	input  wire logic accepted_i,
	input  wire logic acc_pol_i,
	input  wire logic flag_clear_i,
	// scenario control
	input  wire logic ext_go_i,
	input  wire logic mod_go_i,
	// requests
	output logic      ext_req_n_o,
	output logic      mod_req_o
);
	logic [1:0] gap_e;
	logic [1:0] gap_m;
	logic       acc;
	assign acc = accepted_i ^ acc_pol_i;
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gap_e <= 2'h0;
			gap_m <= 2'h0;
			ext_req_n_o <= 1'b1;
			mod_req_o <= 1'b0;
		end else begin
			// held low until taken, then a short gap
			if (acc)
				gap_e <= 2'h3;
			else if (gap_e != 2'h0)
				gap_e <= gap_e - 2'h1;
			ext_req_n_o <= !(ext_go_i && gap_e == 2'h0 && !acc);
			// module flag only drops when the channel clears it
			if (flag_clear_i)
				gap_m <= 2'h3;
			else if (gap_m != 2'h0)
				gap_m <= gap_m - 2'h1;
			mod_req_o <= mod_go_i && gap_m == 2'h0 && !flag_clear_i;
		end
	end
endmodule
`default_nettype wire

// *** testbench/dma_chain_channel_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dma_chain_channel_tb;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] src;
		logic [31:0] dst;
		logic [2:0]  prw;
	} row_t;
	row_t rows [4] = '{
		'{32'h0000_9005, 32'h0000_0101, 32'h0000_01ff, 3'h2},
		'{32'h0000_630d, 32'h0000_00fe, 32'h0000_0202, 3'h5},
		'{32'h0000_5115, 32'h0000_0104, 32'h0000_0204, 3'h6},
		'{32'h0000_8215, 32'h0000_0100, 32'h0000_01fc, 3'h1}};
	logic        clk_sys_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [5:0]  adr = 6'h00;
	logic        rd_r = 1'b0;
	logic        wr_r = 1'b0;
	logic [31:0] wd = 32'h0;
	logic        nmi = 1'b0;
	logic        aerr = 1'b0;
	logic        ext_go = 1'b0;
	logic        mod_go = 1'b0;
	logic        apol = 1'b0;
	logic        kpol = 1'b0;
	logic [31:0] q, rdat, src_a, dst_a;
	logic        wait_r, rcyc, wcyc, acc, ack, fclr, irq, ext_n, mreq;
	int          mismatches = 0;
	int          checks = 0;
	int          n_ack, n_ackr, n_ackw, n_acc, n_clr, i, j;

	dma_chain_channel dma_chain_channel_i (.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd_r),
		.avs_write_i(wr_r), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wait_r), .ext_transfer_request_n_i(ext_n),
		.module_request_i(mreq), .nmi_i(nmi), .addr_error_i(aerr),
		.src_addr_o(src_a), .dst_addr_o(dst_a), .read_cycle_o(rcyc),
		.write_cycle_o(wcyc), .request_accepted_out_o(acc),
		.transfer_ack_out_o(ack), .flag_clear_o(fclr),
		.transfer_end_irq_o(irq));
	req_partner req_partner_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.accepted_i(acc), .acc_pol_i(apol), .flag_clear_i(fclr),
		.ext_go_i(ext_go), .mod_go_i(mod_go), .ext_req_n_o(ext_n),
		.mod_req_o(mreq));

	initial forever #25 clk_sys_i = ~clk_sys_i;

	// outputs are registered, so the falling edge sees them settled
	always @(negedge clk_sys_i) begin
		if (ack === ~kpol) begin
			n_ack++;
			if (rcyc === 1'b1) n_ackr++;
			if (wcyc === 1'b1) n_ackw++;
		end
		if (acc === ~apol) n_acc++;
		if (fclr === 1'b1) n_clr++;
	end

	task automatic fail(input string m);
		mismatches++;
		$display("mismatch at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
		input string m);
		checks++;
		if (g !== e) fail(m);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		wr_r <= w;
		rd_r <= !w;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wait_r !== 1'b0 && n < 50);
		// answer and read data are taken at the edge that ends the wait
		q = rdat;
		if (wait_r !== 1'b0) fail("bus hang");
		wr_r <= 1'b0;
		rd_r <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic do_reset;
		nrst_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		@(posedge clk_sys_i);
	endtask
	// polarity first, with the channel off, so idle levels settle
	task automatic setup(input logic [31:0] cfg, input logic [31:0] cnt,
		input logic [31:0] ctrl);
		bus(1'b1, dma_pkg::OFS_CTRL, ctrl & 32'hffff_fffe);
		bus(1'b1, dma_pkg::OFS_SRC, 32'h0000_0100);
		bus(1'b1, dma_pkg::OFS_DST, 32'h0000_0200);
		bus(1'b1, dma_pkg::OFS_CNT, cnt);
		bus(1'b1, dma_pkg::OFS_CHAIN, 32'h0000_0001);
		bus(1'b1, dma_pkg::OFS_SRCCFG, cfg);
		bus(1'b1, dma_pkg::OFS_MASTER, 32'h0000_0001);
		n_ack = 0;
		n_ackr = 0;
		n_ackw = 0;
		n_acc = 0;
		n_clr = 0;
		bus(1'b1, dma_pkg::OFS_CTRL, ctrl);
	endtask
	task automatic wait_end(input int n);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < n) begin
			@(negedge clk_sys_i);
			k++;
		end
		@(posedge clk_sys_i);
	endtask
	task automatic clear_end;
		bus(1'b0, dma_pkg::OFS_CTRL, 32'h0);
		bus(1'b1, dma_pkg::OFS_CTRL, 32'h0);
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fail("watchdog");
		report_and_stop();
	end

	initial begin
		do_reset();
		chk({31'h0, wait_r}, 32'h1, "waitrequest idle");
		bus(1'b0, dma_pkg::OFS_CTRL, 32'h0);
		chk(q, 32'h0, "ctrl reset");
		bus(1'b1, dma_pkg::OFS_CTRL, 32'hffff_ffff);
		bus(1'b0, dma_pkg::OFS_CTRL, 32'h0);
		chk(q, 32'h004f_fffd, "ctrl readback");
		chk({31'h0, acc}, 32'h1, "accept idle low");
		chk({31'h0, ack}, 32'h1, "ack idle low");
		bus(1'b0, 6'h3c, 32'h0);
		chk(q, 32'h0, "unmapped read");
		$display("test reset done");
		do_reset();
		for (i = 0; i < 4; i++) begin
			kpol = rows[i].prw[2];
			setup(32'h0, 32'h1, rows[i].ctrl);
			wait_end(80);
			chk(src_a, rows[i].src, "src step");
			chk(dst_a, rows[i].dst, "dst step");
			chk(32'(n_ackr), 32'(rows[i].prw[1]), "ack read");
			chk(32'(n_ackw), 32'(rows[i].prw[0]), "ack write");
			chk({31'h0, ack}, 32'(kpol), "ack idle");
			chk({31'h0, irq}, 32'h1, "end irq");
			clear_end();
			chk({31'h0, irq}, 32'h0, "irq cleared");
		end
		$display("test steps done");
		do_reset();
		apol <= 1'b1;
		kpol = 1'b0;
		for (j = 0; j < 2; j++) begin
			setup(j ? 32'h5 : 32'hd, 32'h2, 32'h0001_540d);
			ext_go <= 1'b1;
			wait_end(300);
			ext_go <= 1'b0;
			chk(src_a, j ? 32'h104 : 32'h100, "single src");
			chk(dst_a, j ? 32'h200 : 32'h204, "single dst");
			chk(32'(n_acc), 32'h2, "accepts");
			chk({31'h0, acc}, 32'h1, "accept idle");
			chk(32'(n_ack), 32'h2, "single ack");
			clear_end();
		end
		$display("test single done");
		do_reset();
		apol <= 1'b0;
		for (j = 0; j < 2; j++) begin
			setup(32'h2, 32'h2, j ? 32'h5 : 32'h0003_0045);
			mod_go <= 1'b1;
			wait_end(j ? 150 : 300);
			mod_go <= 1'b0;
			chk(32'(n_clr), j ? 32'h1 : 32'h2, "flag clears");
			chk({31'h0, irq}, j ? 32'h0 : 32'h1, "end timing");
			clear_end();
		end
		$display("test module done");
		for (j = 0; j < 2; j++) begin
			do_reset();
			bus(1'b1, dma_pkg::OFS_NSRC, 32'h0000_0400);
			bus(1'b1, dma_pkg::OFS_NDST, 32'h0000_0500);
			bus(1'b1, dma_pkg::OFS_NCNT, 32'h0000_0001);
			setup(32'h1, 32'h1, j ? 32'h0000_5805 : 32'h000c_5805);
			ext_go <= 1'b1;
			wait_end(300);
			ext_go <= 1'b0;
			chk(src_a, j ? 32'h102 : 32'h401, "chain src");
			chk(dst_a, j ? 32'h202 : 32'h501, "chain dst");
			chk(32'(n_acc), 32'h2, "chain links");
			chk({31'h0, irq}, 32'h1, "chain end");
		end
		$display("test chain done");
		// count zero holds the engine, so the queue fills to its depth
		for (j = 0; j < 2; j++) begin
			do_reset();
			setup(32'h1, 32'h0, j ? 32'h0000_0001 : 32'h0040_0001);
			ext_go <= 1'b1;
			repeat (40) @(posedge clk_sys_i);
			ext_go <= 1'b0;
			repeat (4) @(posedge clk_sys_i);
			bus(1'b1, dma_pkg::OFS_CNT, 32'h0000_0040);
			repeat (100) @(posedge clk_sys_i);
			chk(32'(n_acc), j ? 32'h1 : 32'h10, "queue depth");
		end
		$display("test queue done");
		for (j = 0; j < 2; j++) begin
			do_reset();
			setup(32'h0, 32'h0000_0040, 32'h0000_1005);
			repeat (8) @(posedge clk_sys_i);
			nmi <= (j == 0);
			aerr <= (j == 1);
			@(posedge clk_sys_i);
			nmi <= 1'b0;
			aerr <= 1'b0;
			repeat (300) @(posedge clk_sys_i);
			chk({31'h0, irq}, 32'h0, "early stop");
			bus(1'b0, dma_pkg::OFS_MASTER, 32'h0);
			chk(q, j ? 32'h5 : 32'h3, "stop flag");
		end
		$display("test stop done");
		report_and_stop();
	end
endmodule
`default_nettype wire
